// ---- dual_wiper_serial_slave.sv ----
/*
  Two-wire serial slave for a dual wiper potentiometer: framing, acks,
  wiper and saved-position storage, nonvolatile write busy window.
  Assumes an external master drives the bus clock, a pull-up on data,
  and a bus clock well below a quarter of clk.
*/
`timescale 1ns/1ps
module dual_wiper_serial_slave
  import pot_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = pot_pkg::NV_WRITE_CYCLES_DFLT
)
(
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                scl,
  input  wire logic                sda_in,
  input  wire logic [3:0]          addr_select_pins,
  input  wire logic                wp_n,
  output logic                     sda_out,
  output logic                     sda_oe,
  output logic [pot_pkg::TAP_W-1:0] wiper_pos0,
  output logic [pot_pkg::TAP_W-1:0] wiper_pos1,
  output logic                     nv_busy
);
  import pot_pkg::*;

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    slave_st_e                              st;
    logic                                   in_ack;
    logic [3:0]                             cnt;
    logic [7:0]                             shreg;
    logic [7:0]                             tx;
    logic [3:0]                             op;
    logic [1:0]                             ptr;
    logic                                   ch;
    logic                                   oe;
    logic                                   drv;
    logic [NUM_CH-1:0][TAP_W-1:0]           wiper;
    logic [NUM_CH-1:0][NUM_SAVED-1:0][TAP_W-1:0] saved;
    logic                                   nv_pend;
    logic [7:0]                             pend_data;
    logic                                   busy;
    logic [NV_CNT_W-1:0]                    busy_cnt;
    logic                                   scl_q;
    logic                                   sda_q;
  } slave_s;

  slave_s s_ff;
  slave_s nxt_s;

  logic [SYNC_W-1:0] pins_s;
  logic              scl_s;
  logic              sda_s;
  logic              wp_s;
  logic [3:0]        addr_s;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_ev;
  logic              stop_ev;

  // ***********************************************************
  // pin synchronisation and bus events
  // ***********************************************************
  pin_sync u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({scl, sda_in, wp_n, addr_select_pins}),
    .q    (pins_s)
  );

  // edges are found on the synchronised copies only
  assign scl_s    = pins_s[6];
  assign sda_s    = pins_s[5];
  assign wp_s     = pins_s[4];
  assign addr_s   = pins_s[3:0];
  assign scl_rise = scl_s & ~s_ff.scl_q;
  assign scl_fall = ~scl_s & s_ff.scl_q;
  assign start_ev = scl_s & s_ff.scl_q & s_ff.sda_q & ~sda_s;
  assign stop_ev  = scl_s & s_ff.scl_q & ~s_ff.sda_q & sda_s;

  // value returned for a read instruction
  function automatic logic [7:0] read_value(input slave_s s);
    if (s.op == OP_RD_WIPER) begin
      read_value = s.wiper[s.ch];
    end else begin
      read_value = s.saved[s.ch][s.ptr];
    end
  endfunction : read_value

  // ***********************************************************
  // next-state logic
  // ***********************************************************
  // bus events take priority over bit handling; a start aborts any
  // pending nonvolatile write that was not closed by a stop
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.scl_q = scl_s;
    nxt_s.sda_q = sda_s;
    nxt_s.drv   = 1'b0;
    if (s_ff.busy) begin
      nxt_s.busy_cnt = s_ff.busy_cnt - 1'b1;
      if (s_ff.busy_cnt == NV_CNT_W'(1)) begin
        nxt_s.busy                     = 1'b0;
        nxt_s.saved[s_ff.ch][s_ff.ptr] = s_ff.pend_data;
      end
    end
    if (s_ff.st == ST_RECALL) begin
      for (int c = 0; c < NUM_CH; c++) begin
        nxt_s.wiper[c] = s_ff.saved[c][0];
      end
      nxt_s.st = ST_IDLE;
    end else if (start_ev) begin
      nxt_s.st      = ST_ADDR;
      nxt_s.cnt     = 4'h0;
      nxt_s.in_ack  = 1'b0;
      nxt_s.oe      = 1'b0;
      nxt_s.nv_pend = 1'b0;
    end else if (stop_ev) begin
      nxt_s.st     = ST_IDLE;
      nxt_s.oe     = 1'b0;
      nxt_s.in_ack = 1'b0;
      if (s_ff.nv_pend) begin
        nxt_s.nv_pend  = 1'b0;
        nxt_s.busy     = 1'b1;
        nxt_s.busy_cnt = NV_CNT_W'(NV_WRITE_CYCLES);
      end
    end else if (s_ff.in_ack) begin
      // end of our ack slot; a read drives its first bit here
      if (scl_fall) begin
        nxt_s.in_ack = 1'b0;
        nxt_s.cnt    = 4'h0;
        nxt_s.oe     = 1'b0;
        if (s_ff.st == ST_RDATA) begin
          nxt_s.oe  = ~s_ff.tx[7];
          nxt_s.tx  = {s_ff.tx[6:0], 1'b0};
          nxt_s.cnt = 4'h1;
        end
      end
    end else if (s_ff.st == ST_RDATA) begin
      if (scl_fall && s_ff.cnt < BYTE_BITS) begin
        nxt_s.oe  = ~s_ff.tx[7];
        nxt_s.tx  = {s_ff.tx[6:0], 1'b0};
        nxt_s.cnt = s_ff.cnt + 4'h1;
      end else if (scl_fall && s_ff.cnt == BYTE_BITS) begin
        nxt_s.oe  = 1'b0;
        nxt_s.cnt = MASTER_ACK_BIT;
      end else if (scl_rise && s_ff.cnt == MASTER_ACK_BIT) begin
        if (sda_s) begin
          nxt_s.st = ST_WAIT_STOP;
        end else begin
          nxt_s.tx  = read_value(s_ff);
          nxt_s.cnt = 4'h0;
        end
      end
    end else if (s_ff.st == ST_ADDR || s_ff.st == ST_INSTR ||
                 s_ff.st == ST_WDATA) begin
      if (scl_rise && s_ff.cnt < BYTE_BITS) begin
        nxt_s.shreg = {s_ff.shreg[6:0], sda_s};
        nxt_s.cnt   = s_ff.cnt + 4'h1;
      end else if (scl_fall && s_ff.cnt == BYTE_BITS) begin
        // default answer is no ack and drop out until next start
        nxt_s.st = ST_WAIT_STOP;
        unique case (s_ff.st)
          ST_ADDR: begin
            if (s_ff.shreg[7:ID_LSB] == DEVICE_TYPE_ID &&
                s_ff.shreg[3:0] == addr_s && !s_ff.busy) begin
              nxt_s.st     = ST_INSTR;
              nxt_s.in_ack = 1'b1;
              nxt_s.oe     = 1'b1;
            end
          end
          ST_INSTR: begin
            nxt_s.op  = s_ff.shreg[7:OP_LSB];
            nxt_s.ptr = s_ff.shreg[PTR_LSB+1:PTR_LSB];
            nxt_s.ch  = s_ff.shreg[CH_BIT];
            if (s_ff.shreg[7:OP_LSB] == OP_RD_WIPER ||
                s_ff.shreg[7:OP_LSB] == OP_RD_SAVED) begin
              nxt_s.st     = ST_RDATA;
              nxt_s.tx     = read_value(nxt_s);
              nxt_s.in_ack = 1'b1;
              nxt_s.oe     = 1'b1;
            end else if (s_ff.shreg[7:OP_LSB] == OP_WR_WIPER ||
                         s_ff.shreg[7:OP_LSB] == OP_WR_SAVED) begin
              nxt_s.st     = ST_WDATA;
              nxt_s.in_ack = 1'b1;
              nxt_s.oe     = 1'b1;
            end
          end
          ST_WDATA: begin
            if (s_ff.op == OP_WR_WIPER) begin
              nxt_s.wiper[s_ff.ch] = s_ff.shreg;
              nxt_s.in_ack         = 1'b1;
              nxt_s.oe             = 1'b1;
            end else if (wp_s) begin
              nxt_s.pend_data = s_ff.shreg;
              nxt_s.nv_pend   = 1'b1;
              nxt_s.in_ack    = 1'b1;
              nxt_s.oe        = 1'b1;
            end
          end
          default: begin
            nxt_s.st = ST_WAIT_STOP;
          end
        endcase
      end
    end
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  // saved registers come up at a fixed value; real retention is
  // outside the scope of this logic
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_ff       <= '0;
      s_ff.st    <= ST_RECALL;
      s_ff.saved <= {(NUM_CH*NUM_SAVED){SAVED_RESET}};
      s_ff.scl_q <= 1'b1;
      s_ff.sda_q <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sda_out    = s_ff.drv;
  assign sda_oe     = s_ff.oe;
  assign wiper_pos0 = s_ff.wiper[0];
  assign wiper_pos1 = s_ff.wiper[1];
  assign nv_busy    = s_ff.busy;

  // ***********************************************************
  // checks
  // ***********************************************************
  a_sample_rise: assert property (@(posedge clk) disable iff (!nrst)
    $changed(s_ff.shreg) |-> $past(scl_rise))
    else $error("shift register moved without a bus clock rise");

  a_drive_fall: assert property (@(posedge clk) disable iff (!nrst)
    $changed(sda_oe) |-> $past(scl_fall || start_ev || stop_ev))
    else $error("data output changed off a falling edge");

  a_open_drain: assert property (@(posedge clk) disable iff (!nrst)
    sda_out == 1'b0)
    else $error("data output would drive high");

  a_addr_match: assert property (@(posedge clk) disable iff (!nrst)
    ($past(s_ff.st) == ST_ADDR && s_ff.st == ST_INSTR)
      |-> $past(s_ff.shreg[3:0] == addr_s))
    else $error("accepted an address that does not match");

  a_power_recall: assert property (@(posedge clk) disable iff (!nrst)
    s_ff.st == ST_RECALL |=> wiper_pos0 == $past(s_ff.saved[0][0]) &&
      wiper_pos1 == $past(s_ff.saved[1][0]) && s_ff.st == ST_IDLE)
    else $error("power-up recall did not load the wipers");

  a_wp_refuse: assert property (@(posedge clk) disable iff (!nrst)
    ($past(s_ff.st) == ST_WDATA && s_ff.st == ST_WAIT_STOP &&
     !$past(wp_s) && $past(s_ff.op) == OP_WR_SAVED)
      |-> !s_ff.nv_pend && !sda_oe)
    else $error("saved write taken while write protect low");

  a_instr_ack: assert property (@(posedge clk) disable iff (!nrst)
    ($past(s_ff.st) == ST_ADDR && s_ff.st == ST_INSTR)
      |-> sda_oe && s_ff.in_ack)
    else $error("matching address was not acknowledged");

  a_busy_nack: assert property (@(posedge clk) disable iff (!nrst)
    (s_ff.st == ST_ADDR && nv_busy && scl_fall &&
     s_ff.cnt == BYTE_BITS && !s_ff.in_ack)
      |=> !sda_oe && s_ff.st == ST_WAIT_STOP)
    else $error("address acked during nonvolatile write");

  a_busy_window: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nv_busy) |-> nv_busy [*8])
    else $error("nonvolatile busy window ended too soon");

  a_mismatch_quiet: assert property (@(posedge clk) disable iff (!nrst)
    ($past(s_ff.st) == ST_ADDR && s_ff.st == ST_WAIT_STOP)
      |-> !sda_oe ##1 !sda_oe)
    else $error("device drove the bus after an address mismatch");

  a_wiper_volatile: assert property (@(posedge clk) disable iff (!nrst)
    ($changed(s_ff.wiper) && $past(s_ff.st) == ST_WDATA)
      |-> !s_ff.nv_pend && !nv_busy)
    else $error("wiper write started a nonvolatile cycle");

endmodule : dual_wiper_serial_slave

// ---- pot_pkg.sv ----
/*
  Shared constants and types for the dual wiper two-wire slave.
  Assumes a 25 MHz system clock and a bus clock far slower than it.
*/
package pot_pkg;

  // ***********************************************************
  // clock and timing
  // ***********************************************************
  localparam int CLK_MHZ             = 25;
  localparam int NV_WRITE_US         = 5000;   // nonvolatile write, us
  localparam int NV_WRITE_CYCLES_DFLT = NV_WRITE_US * CLK_MHZ;
  localparam int NV_CNT_W            = 17;

  // ***********************************************************
  // frame layout
  // ***********************************************************
  localparam logic [3:0] DEVICE_TYPE_ID = 4'hA;  // arbitrary value
  localparam int         ID_LSB         = 4;
  localparam int         OP_LSB         = 4;
  localparam int         PTR_LSB        = 2;
  localparam int         CH_BIT         = 0;
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [3:0] MASTER_ACK_BIT = 4'h9;

  // instruction opcodes
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_SAVED = 4'hB;
  localparam logic [3:0] OP_WR_SAVED = 4'hC;

  // ***********************************************************
  // storage and reset values
  // ***********************************************************
  localparam int         NUM_CH      = 2;
  localparam int         NUM_SAVED   = 4;
  localparam int         TAP_W       = 8;
  localparam logic [7:0] SAVED_RESET = 8'h80;
  localparam int         SYNC_W      = 7;
  localparam logic [6:0] SYNC_RESET  = 7'h7F;

  typedef enum logic [2:0] {
    ST_RECALL,
    ST_IDLE,
    ST_ADDR,
    ST_INSTR,
    ST_WDATA,
    ST_RDATA,
    ST_WAIT_STOP
  } slave_st_e;

endpackage : pot_pkg

// ---- pin_sync.sv ----
/*
  Two-flop synchroniser for the bus pins, the write protect pin and
  the address select straps. Assumes the pins are asynchronous to clk.
*/
`timescale 1ns/1ps
module pin_sync
  import pot_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [SYNC_W-1:0] d,
  output logic      [SYNC_W-1:0] q
);

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] sync;
  } sync_s;

  sync_s s_ff;
  sync_s nxt_s;

  // first stage feeds only the second stage
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.meta = d;
    nxt_s.sync = s_ff.meta;
  end

  // idle-high reset so no false start is seen after release
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_ff <= {SYNC_RESET, SYNC_RESET};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q = s_ff.sync;

endmodule : pin_sync

// ---- bus_master_model.sv ----
/*
  Behavioural two-wire bus master standing on the far side of the slave.
  Assumes the bench resolves the pulled-up data wire from both drivers
  and calls every task just after a rising edge of the 40 ns clock.
*/
`timescale 1ns/1ps
module bus_master_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // ************************************************************
  // bus phases
  // ************************************************************
  localparam time QTR = 80ns;  // quarter of the 320 ns bus clock

  // idle bus: clock stands high, data released to the pull-up
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // data falls while the clock is high, then the clock goes low
  task automatic start();
    sda_low = 1'b0;
    #(2*QTR) sda_low = 1'b1;
    #(2*QTR) scl = 1'b0;
  endtask : start

  // nine clocks; data only moves in the low phase, read at mid-high
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #QTR sda_low = ~tx[i];  // a one releases the wire
      #QTR scl = 1'b1;
      #QTR rx[i] = sda;
      #QTR scl = 1'b0;
    end
  endtask : xfer

  // data rises while the clock is high; the clock then stands still
  task automatic stop();
    #QTR sda_low = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b0;
    #QTR;
  endtask : stop

endmodule : bus_master_model

// ---- testbench.sv ----
/*
  Self-checking bench for the dual wiper two-wire slave.
  Assumes a pull-up on data and one device on the bus.
*/
`timescale 1ns/1ps
module testbench;
  import pot_pkg::*;
  // ************************************************************
  // setup
  // ************************************************************
  localparam int         NV_CYC = 200;  // long enough to poll inside
  localparam logic [3:0] STRAP  = 4'h5;
  localparam logic [7:0] ADDR   = {DEVICE_TYPE_ID, STRAP};

  logic             clk;
  logic             nrst;
  logic             scl;
  logic             m_low;
  logic             wp_n;
  wire  logic       sda;
  logic             sda_out;
  logic             sda_oe;
  logic             nv_busy;
  logic [TAP_W-1:0] wiper_pos0;
  logic [TAP_W-1:0] wiper_pos1;
  int               error_cnt;
  int               samples_checked;

  // either party pulling low wins over the pull-up
  assign sda = ~(m_low | sda_oe);

  dual_wiper_serial_slave #(.NV_WRITE_CYCLES(NV_CYC)) dut_u (
    .clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda),
    .addr_select_pins(STRAP), .wp_n(wp_n), .sda_out(sda_out),
    .sda_oe(sda_oe), .wiper_pos0(wiper_pos0), .wiper_pos1(wiper_pos1),
    .nv_busy(nv_busy));

  bus_master_model master_u (.scl(scl), .sda_low(m_low), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(string what, logic [8:0] seen, logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // open drain: whenever the pin is driven it must be driven low;
  // looked at mid-cycle so the flops have settled
  always @(negedge clk) begin
    if (sda_oe === 1'b1) check("sda_out", 9'(sda_out), 9'h0);
  end

  // ************************************************************
  // transfers
  // ************************************************************
  // one full frame: address, instruction, then a data or read byte
  task automatic frame(input logic [7:0] a, input logic [7:0] ins,
                       input logic [7:0] d, input logic rd,
                       output logic [2:0] ak, output logic [7:0] rx);
    logic [8:0] r;
    @(posedge clk);
    #1 master_u.start();
    master_u.xfer({a, 1'b1}, r);
    ak[2] = ~r[0];
    master_u.xfer({ins, 1'b1}, r);
    ak[1] = ~r[0];
    master_u.xfer(rd ? 9'h1FF : {d, 1'b1}, r);  // read ends with nack
    ak[0] = rd ? 1'b0 : ~r[0];
    rx = r[8:1];
    master_u.stop();
  endtask : frame

  task automatic poll(output logic ak);
    logic [8:0] r;
    @(posedge clk);
    #1 master_u.start();
    master_u.xfer({ADDR, 1'b1}, r);
    ak = ~r[0];
    master_u.stop();
  endtask : poll

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_wiper();
    logic [2:0] ak;
    logic [7:0] rx;
    frame(ADDR, {OP_WR_WIPER, 4'h0}, 8'hA3, 1'b0, ak, rx);
    check("acks wr0", 9'(ak), 9'h7);
    check("wiper0", 9'(wiper_pos0), 9'hA3);
    check("wiper1 kept", 9'(wiper_pos1), 9'h80);
    frame(ADDR, {OP_WR_WIPER, 4'h1}, 8'h5C, 1'b0, ak, rx);
    check("wiper1", 9'(wiper_pos1), 9'h5C);
    check("no nv cycle", 9'(nv_busy), 9'h0);
    frame(ADDR, {OP_RD_WIPER, 4'h0}, 8'h00, 1'b1, ak, rx);
    check("acks rd", 9'(ak), 9'h6);
    check("rd wiper0", 9'(rx), 9'hA3);
    frame(ADDR, {OP_RD_WIPER, 4'h1}, 8'h00, 1'b1, ak, rx);
    check("rd wiper1", 9'(rx), 9'h5C);
  endtask : t_wiper

  // a neighbour's address or a wrong type id: no ack and the rest of the frame is ignored
  task automatic t_mismatch();
    logic [2:0] ak;
    logic [7:0] rx;
    frame({DEVICE_TYPE_ID, STRAP ^ 4'h8}, {OP_WR_WIPER, 4'h0}, 8'h11,
          1'b0, ak, rx);
    check("acks other", 9'(ak), 9'h0);
    check("wiper0 kept", 9'(wiper_pos0), 9'hA3);
    frame({~DEVICE_TYPE_ID, STRAP}, {OP_WR_WIPER, 4'h0}, 8'h12,
          1'b0, ak, rx);
    check("acks bad id", 9'(ak), 9'h0);
    // undecoded opcode: address acked, instruction refused
    frame(ADDR, {4'h3, 4'h0}, 8'h22, 1'b0, ak, rx);
    check("acks bad op", 9'(ak), 9'h4);
    check("wiper0 bad op", 9'(wiper_pos0), 9'hA3);
  endtask : t_mismatch

  // every pointer code, alternating channels, with busy polling
  task automatic t_saved();
    logic [2:0] ak;
    logic [7:0] rx;
    logic       pa;
    int         n;
    for (int p = 0; p < 4; p++) begin
      frame(ADDR, {OP_WR_SAVED, 2'(p), 1'b0, 1'(p)}, 8'h31 + 8'(p),
            1'b0, ak, rx);
      check("acks nv", 9'(ak), 9'h7);
      repeat (4) @(posedge clk);
      check("busy", 9'(nv_busy), 9'h1);
      poll(pa);
      check("busy poll", 9'(pa), 9'h0);
      n = 0;
      while (pa !== 1'b1 && n < 20) begin
        poll(pa);
        n++;
      end
      if (pa !== 1'b1) begin
        check("poll bound", 9'h0, 9'h1);
        report_and_stop();
      end
    end
    for (int p = 0; p < 4; p++) begin
      frame(ADDR, {OP_RD_SAVED, 2'(p), 1'b0, 1'(p)}, 8'h00, 1'b1, ak, rx);
      check("rd saved", 9'(rx), 9'h31 + 9'(p));
      frame(ADDR, {OP_RD_SAVED, 2'(p), 1'b0, ~1'(p)}, 8'h00, 1'b1, ak, rx);
      check("other ch saved", 9'(rx), 9'h80);
    end
  endtask : t_saved

  // protect low: data byte refused, nothing stored, no busy window
  task automatic t_protect();
    logic [2:0] ak;
    logic [7:0] rx;
    @(posedge clk);
    #1 wp_n = 1'b0;
    repeat (4) @(posedge clk);
    frame(ADDR, {OP_WR_SAVED, 4'h5}, 8'h77, 1'b0, ak, rx);
    check("acks wp", 9'(ak), 9'h6);
    repeat (4) @(posedge clk);
    check("wp no busy", 9'(nv_busy), 9'h0);
    frame(ADDR, {OP_RD_SAVED, 4'h5}, 8'h00, 1'b1, ak, rx);
    check("wp kept", 9'(rx), 9'h32);
    @(posedge clk);
    #1 wp_n = 1'b1;
  endtask : t_protect

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    error_cnt       = 0;
    samples_checked = 0;
    nrst            = 1'b0;
    wp_n            = 1'b1;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (10) @(posedge clk);
    check("recall0", 9'(wiper_pos0), 9'h80);
    check("recall1", 9'(wiper_pos1), 9'h80);
    t_wiper();
    t_mismatch();
    t_saved();
    t_protect();
    report_and_stop();
  end

endmodule : testbench
